// ===== logic/clock_edge_detect.sv
// Purpose: Finds rising and falling edges of capture and launch clocks.
// Assumes: Both clocks are synchronous inputs slower than clk_sys / 2.
// Notes: Edge pulses are combinational from the input and last level.
`timescale 1ns/1ns
`default_nettype none
module clock_edge_detect
   import gpio_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic capture_clock,
   input wire logic launch_clock,
   clock_edge_if.producer edges
);
   logic capture_last_q; // Capture clock one cycle ago
   logic capture_last_d;
   logic launch_last_q; // Launch clock one cycle ago
   logic launch_last_d;

   // Next values of the remembered levels
   always_comb
   begin
      capture_last_d = capture_clock;
      launch_last_d = launch_clock;
   end

   // Level history registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         capture_last_q <= RST_BIT;
         launch_last_q <= RST_BIT;
      end
      else
      begin
         capture_last_q <= capture_last_d;
         launch_last_q <= launch_last_d;
      end
   end

   // Edge events from level change
   assign edges.capture_rise = capture_clock & ~capture_last_q;
   assign edges.capture_fall = ~capture_clock & capture_last_q;
   assign edges.launch_rise = launch_clock & ~launch_last_q;
   assign edges.launch_fall = ~launch_clock & launch_last_q;
   assign edges.launch_high = launch_clock;
endmodule
`default_nettype wire

// ===== logic/gpio_double_rate_mode_interface_logic.sv
// Purpose: Per-pad I/O logic between core fabric and one two-way pad.
// Assumes: Core clocks arrive as synchronous levels, sampled on clk_sys.
// Notes: Every output is registered, so direct paths add one cycle.
`timescale 1ns/1ns
`default_nettype none
module gpio_double_rate_mode_interface_logic
   import gpio_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic capture_clock,
   input wire logic launch_clock,
   input wire logic in_reg_en,
   input wire logic in_edge_sel,
   input wire logic out_reg_en,
   input wire logic out_edge_sel,
   input wire logic oe_reg_en,
   input wire logic oe_edge_sel,
   input wire logic out_invert,
   input wire logic in_double_rate_mode,
   input wire logic out_double_rate_mode,
   input wire logic in_resync,
   input wire logic out_resync,
   input wire logic single_ended_lvds,
   input wire logic [PAIR_W-1:0] core_out,
   input wire logic core_oe,
   input wire logic pad_in,
   output logic [PAIR_W-1:0] core_in,
   output logic alternate_unregistered_input,
   output logic pad_out,
   output logic pad_oe
);
   // Edge events of the two core clocks
   clock_edge_if edges ();

   // Edge finder for capture and launch clocks
   clock_edge_detect u_edges (
      .clk_sys(clk_sys),
      .rst(rst),
      .capture_clock(capture_clock),
      .launch_clock(launch_clock),
      .edges(edges.producer)
   );

   // Effective double rate, gated off on single-ended LVDS pads
   logic in_ddr; // Input double rate in force
   logic out_ddr; // Output double rate in force
   assign in_ddr = in_double_rate_mode & ~single_ended_lvds;
   assign out_ddr = out_double_rate_mode & ~single_ended_lvds;

   // Selected single-rate edges of each clock
   logic in_edge; // Chosen capture edge this cycle
   logic out_edge; // Chosen launch edge for data
   logic oe_edge; // Chosen launch edge for enable
   assign in_edge = (in_edge_sel == EDGE_FALLING) ?
                    edges.capture_fall : edges.capture_rise;
   assign out_edge = (out_edge_sel == EDGE_FALLING) ?
                     edges.launch_fall : edges.launch_rise;
   assign oe_edge = (oe_edge_sel == EDGE_FALLING) ?
                    edges.launch_fall : edges.launch_rise;

   // Input path state
   logic [PAIR_W-1:0] core_in_q; // Word shown to the core
   logic [PAIR_W-1:0] core_in_d;
   logic rising_sample_q; // Pad sampled at capture rise
   logic rising_sample_d;
   logic falling_sample_q; // Pad sampled at capture fall
   logic falling_sample_d;
   logic bypass_q; // Alternate path copy of the pad
   logic bypass_d;

   // Output path state
   logic rising_launch_q; // Bit for the high phase
   logic rising_launch_d;
   logic falling_launch_q; // Bit for the low phase
   logic falling_launch_d;
   logic out_hold_q; // Single-rate output register
   logic out_hold_d;
   logic pad_out_q; // Value on the pad driver
   logic pad_out_d;

   // Enable path state
   logic oe_hold_q; // Registered output enable
   logic oe_hold_d;
   logic pad_oe_q; // Enable on the pad driver
   logic pad_oe_d;

   // Input path next values, on capture clock edges except in the direct path
   always_comb
   begin
      core_in_d = core_in_q;
      rising_sample_d = rising_sample_q;
      falling_sample_d = falling_sample_q;
      if (in_ddr)
      begin
         // Double rate: sample on both capture edges
         if (edges.capture_rise)
         begin
            rising_sample_d = pad_in;
         end
         if (edges.capture_fall)
         begin
            falling_sample_d = pad_in;
         end
         if (in_resync)
         begin
            // Resync: pair last rise with the fall after it
            if (edges.capture_rise)
            begin
               core_in_d[RISE_POS] = rising_sample_q;
               core_in_d[FALL_POS] = falling_sample_q;
            end
         end
         else
         begin
            // Normal: each bit moves on its own edge
            if (edges.capture_rise)
            begin
               core_in_d[RISE_POS] = pad_in;
            end
            if (edges.capture_fall)
            begin
               core_in_d[FALL_POS] = pad_in;
            end
         end
      end
      else if (in_reg_en)
      begin
         // Single rate registered on the chosen edge
         core_in_d[FALL_POS] = 1'b0;
         if (in_edge)
         begin
            core_in_d[RISE_POS] = pad_in;
         end
      end
      else
      begin
         // Single rate direct path
         core_in_d[FALL_POS] = 1'b0;
         core_in_d[RISE_POS] = pad_in;
      end
   end

   // Alternate path next value, live only with no input register
   always_comb
   begin
      bypass_d = 1'b0;
      if (!in_reg_en && !in_ddr)
      begin
         bypass_d = pad_in;
      end
   end

   // Input path registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         core_in_q <= RST_PAIR;
         rising_sample_q <= RST_BIT;
         falling_sample_q <= RST_BIT;
         bypass_q <= RST_BIT;
      end
      else
      begin
         core_in_q <= core_in_d;
         rising_sample_q <= rising_sample_d;
         falling_sample_q <= falling_sample_d;
         bypass_q <= bypass_d;
      end
   end

   // Output data next values, on launch clock edges except in the direct path
   always_comb
   begin
      rising_launch_d = rising_launch_q;
      falling_launch_d = falling_launch_q;
      out_hold_d = out_hold_q;
      pad_out_d = pad_out_q;
      if (out_ddr)
      begin
         if (out_resync)
         begin
            // Resync: both bits taken at launch rise
            if (edges.launch_rise)
            begin
               rising_launch_d = core_out[RISE_POS];
               falling_launch_d = core_out[FALL_POS];
            end
         end
         else
         begin
            // Normal: each bit taken on its own edge
            if (edges.launch_rise)
            begin
               rising_launch_d = core_out[RISE_POS];
            end
            if (edges.launch_fall)
            begin
               falling_launch_d = core_out[FALL_POS];
            end
         end
         // High phase shows bit0, low phase shows bit1
         if (edges.launch_high)
         begin
            pad_out_d = rising_launch_d ^ out_invert;
         end
         else
         begin
            pad_out_d = falling_launch_d ^ out_invert;
         end
      end
      else if (out_reg_en)
      begin
         // Single rate registered on the chosen launch edge
         if (out_edge)
         begin
            out_hold_d = core_out[RISE_POS];
         end
         pad_out_d = out_hold_d ^ out_invert;
      end
      else
      begin
         // Single rate direct path, no register to invert
         pad_out_d = core_out[RISE_POS];
      end
   end

   // Output data registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rising_launch_q <= RST_BIT;
         falling_launch_q <= RST_BIT;
         out_hold_q <= RST_BIT;
         pad_out_q <= RST_BIT;
      end
      else
      begin
         rising_launch_q <= rising_launch_d;
         falling_launch_q <= falling_launch_d;
         out_hold_q <= out_hold_d;
         pad_out_q <= pad_out_d;
      end
   end

   // Output enable next values
   always_comb
   begin
      oe_hold_d = oe_hold_q;
      if (oe_reg_en)
      begin
         // Registered on the chosen launch edge
         if (oe_edge)
         begin
            oe_hold_d = core_oe;
         end
         pad_oe_d = oe_hold_d;
      end
      else
      begin
         // Direct from the core
         pad_oe_d = core_oe;
      end
   end

   // Output enable registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         oe_hold_q <= RST_BIT;
         pad_oe_q <= RST_BIT;
      end
      else
      begin
         oe_hold_q <= oe_hold_d;
         pad_oe_q <= pad_oe_d;
      end
   end

   // Ports straight from flip-flops
   assign core_in = core_in_q;
   assign alternate_unregistered_input = bypass_q;
   assign pad_out = pad_out_q;
   assign pad_oe = pad_oe_q;
endmodule
`default_nettype wire

// ===== shared/clock_edge_if.sv
// Purpose: Carries edge events of the core-supplied clocks.
// Assumes: Producer samples both clocks on the system clock.
// Notes: Pulses last one system clock cycle.
`timescale 1ns/1ns
`default_nettype none
interface clock_edge_if;
   logic capture_rise; // Capture clock went high
   logic capture_fall; // Capture clock went low
   logic launch_rise; // Launch clock went high
   logic launch_fall; // Launch clock went low
   logic launch_high; // Present level of the launch clock
   // Edge finder side
   modport producer (
      output capture_rise,
      output capture_fall,
      output launch_rise,
      output launch_fall,
      output launch_high
   );
   // Pad logic side
   modport consumer (
      input capture_rise,
      input capture_fall,
      input launch_rise,
      input launch_fall,
      input launch_high
   );
endinterface
`default_nettype wire

// ===== shared/gpio_pkg.sv
// Purpose: Shared constants for the pad I/O logic block.
// Assumes: Single system clock; pad and core clocks are sampled levels.
// Notes: Edge select encoding and reset values live here only.
package gpio_pkg;
   // Edge select encoding for every optional register
   localparam logic EDGE_RISING = 1'b0;
   localparam logic EDGE_FALLING = 1'b1;
   // Reset value of single state bits
   localparam logic RST_BIT = 1'b0;
   // Reset value of the two-bit core input word
   localparam logic [1:0] RST_PAIR = 2'h0;
   // Bit positions of the two-bit core words
   localparam int RISE_POS = 0;
   localparam int FALL_POS = 1;
   // Width of the core data words
   localparam int PAIR_W = 2;
endpackage

// ===== tb/gpio_chk_sva.sv
// Purpose: Port checks for the pad I/O logic.
// Assumes: Core clock levels hold two or more clk_sys cycles.
// Notes: Results land one clk_sys after the edge that causes them.
`timescale 1ns/1ns
`default_nettype none
module gpio_chk
   import gpio_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic capture_clock,
   input wire logic launch_clock,
   input wire logic in_reg_en,
   input wire logic in_edge_sel,
   input wire logic out_reg_en,
   input wire logic out_edge_sel,
   input wire logic oe_reg_en,
   input wire logic oe_edge_sel,
   input wire logic out_invert,
   input wire logic in_double_rate_mode,
   input wire logic out_double_rate_mode,
   input wire logic in_resync,
   input wire logic out_resync,
   input wire logic single_ended_lvds,
   input wire logic [PAIR_W-1:0] core_out,
   input wire logic core_oe,
   input wire logic pad_in,
   input wire logic [PAIR_W-1:0] core_in,
   input wire logic alternate_unregistered_input,
   input wire logic pad_out,
   input wire logic pad_oe
);
   logic live_q; // History clear of reset
   wire logic ddr_i = in_double_rate_mode && !single_ended_lvds;
   wire logic ddr_o = out_double_rate_mode && !single_ended_lvds;
   wire logic [2:0] icfg = {in_reg_en, ddr_i, in_resync};
   // Opens the checks one cycle after reset
   always_ff @(posedge clk_sys)
   begin
      live_q <= !rst;
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   logic cap_q; // Capture clock one cycle ago
   logic rs_q; // Pad at the last double-rate rise
   logic fs_q; // Pad at the last double-rate fall
   // Reference model of the double-rate samples
   always_ff @(posedge clk_sys)
   begin
      cap_q <= capture_clock;
      if (ddr_i && capture_clock && !cap_q)
      begin
         rs_q <= pad_in;
      end
      if (ddr_i && !capture_clock && cap_q)
      begin
         fs_q <= pad_in;
      end
   end
   property p_bypass;
      live_q |=> alternate_unregistered_input ==
         $past(!in_reg_en && !ddr_i && pad_in);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass path");
   property p_in_sdr;
      live_q && in_reg_en && !ddr_i && (in_edge_sel == EDGE_FALLING ?
         $fell(capture_clock) : $rose(capture_clock))
         |=> core_in == {1'b0, $past(pad_in)};
   endproperty
   a_in_sdr: assert property (p_in_sdr) else $error("in reg");
   property p_in_hold;
      live_q && (in_reg_en || ddr_i) && $stable(capture_clock) &&
         $stable(icfg) |=> $stable(core_in);
   endproperty
   a_in_hold: assert property (p_in_hold) else $error("in hold");
   property p_in_ddr;
      live_q && ddr_i && !in_resync && !$stable(capture_clock) |=>
         ($past(capture_clock) ? core_in[0] : core_in[1]) == $past(pad_in);
   endproperty
   a_in_ddr: assert property (p_in_ddr) else $error("in ddr");
   property p_out_sdr;
      live_q && out_reg_en && !ddr_o && (out_edge_sel == EDGE_FALLING ?
         $fell(launch_clock) : $rose(launch_clock))
         |=> pad_out == $past(core_out[0] ^ out_invert);
   endproperty
   a_out_sdr: assert property (p_out_sdr) else $error("out reg");
   property p_out_dir;
      live_q && !out_reg_en && !ddr_o |=> pad_out == $past(core_out[0]);
   endproperty
   a_out_dir: assert property (p_out_dir) else $error("out dir");
   property p_oe;
      live_q && (!oe_reg_en || (oe_edge_sel == EDGE_FALLING ?
         $fell(launch_clock) : $rose(launch_clock)))
         |=> pad_oe == $past(core_oe);
   endproperty
   a_oe: assert property (p_oe) else $error("enable");
   property p_out_ddr;
      live_q && ddr_o && !out_resync && !$stable(launch_clock) |=> pad_out ==
         $past((launch_clock ? core_out[0] : core_out[1]) ^ out_invert);
   endproperty
   a_out_ddr: assert property (p_out_ddr) else $error("out ddr");
   // Resync input: a rise presents the previous rise and fall pair
   sequence s_rsy_rise;
      live_q && ddr_i && in_resync && $rose(capture_clock);
   endsequence
   sequence s_rsy_pair;
      core_in == $past({fs_q, rs_q});
   endsequence
   property p_in_rsy;
      s_rsy_rise |=> s_rsy_pair;
   endproperty
   a_in_rsy: assert property (p_in_rsy) else $error("in resync");
   property p_out_rsy;
      live_q && ddr_o && out_resync && $rose(launch_clock) |=>
         pad_out == $past(core_out[0] ^ out_invert);
   endproperty
   a_out_rsy: assert property (p_out_rsy) else $error("out resync");
endmodule
bind gpio_double_rate_mode_interface_logic gpio_chk u_chk (.*);
`default_nettype wire

// ===== tb/pad_model.sv
// Purpose: Far end of the two-way pad.
// Assumes: Our driver wins the pad whenever enabled.
// Notes: Far end drives ext_val while the pad is released.
`timescale 1ns/1ns
`default_nettype none
module pad_model
(
   input wire logic drive_en,
   input wire logic drive_val,
   input wire logic ext_val,
   output logic pad_level
);
   // Resolve the pad level from both parties
   assign pad_level = drive_en ? drive_val : ext_val;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the pad I/O logic.
// Assumes: Core clocks are slow levels driven by the bench.
// Notes: Outputs are judged at a falling clk_sys edge.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic cap, lch, ire, ies, ore, oes, oer, oee, inv, idr, odr, irs, ors;
   logic sel, coe, pin, byp, po, poe, ext;
   logic [1:0] co, ci;
   int n_fail = 0;
   int checks = 0;
   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;
   gpio_double_rate_mode_interface_logic u_dut (
      .clk_sys(clk_sys), .rst(rst), .capture_clock(cap),
      .launch_clock(lch), .in_reg_en(ire), .in_edge_sel(ies),
      .out_reg_en(ore), .out_edge_sel(oes), .oe_reg_en(oer),
      .oe_edge_sel(oee), .out_invert(inv), .in_double_rate_mode(idr),
      .out_double_rate_mode(odr), .in_resync(irs), .out_resync(ors),
      .single_ended_lvds(sel), .core_out(co), .core_oe(coe), .pad_in(pin),
      .core_in(ci), .alternate_unregistered_input(byp), .pad_out(po),
      .pad_oe(poe)
   );
   pad_model u_pad (.drive_en(poe), .drive_val(po), .ext_val(ext),
      .pad_level(pin));
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
      checks++;
      if (seen !== exp)
      begin
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask
   // Let a core clock edge reach the outputs
   task settle;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // Capture clock level with pad value
   task ec(input logic l, input logic p);
      @(posedge clk_sys);
      cap <= l;
      ext <= p;
      settle();
   endtask
   // Launch clock level with core data and enable
   task el(input logic l, input logic [1:0] d, input logic o);
      @(posedge clk_sys);
      lch <= l;
      co <= d;
      coe <= o;
      settle();
   endtask
   task t_direct;
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk_sys);
         ext <= v[0];
         co <= {1'b1, ~v[0]};
         settle();
         chk("core_in", ci, {1'b0, v[0]});
         chk("alternate", byp, v[0]);
         chk("pad_out", po, {1'b0, ~v[0]});
         chk("pad_oe", poe, 1'b0);
      end
      $display("direct done");
   endtask
   task t_in_sdr;
      for (int e = 0; e < 2; e++)
      begin
         @(posedge clk_sys);
         ire <= 1'b1;
         ies <= e[0];
         ec(1'b1, 1'b0);
         ec(1'b0, 1'b0);
         ec(1'b1, 1'b1);
         chk("core_in rise", ci, {1'b0, ~e[0]});
         ec(1'b0, 1'b1);
         chk("core_in fall", ci, 2'h1);
         @(posedge clk_sys);
         ext <= 1'b0;
         lch <= ~lch;
         settle();
         chk("core_in hold", ci, 2'h1);
         chk("alternate", byp, 1'b0);
      end
      $display("input register done");
   endtask
   task t_in_ddr(input logic se);
      @(posedge clk_sys);
      idr <= 1'b1;
      irs <= 1'b0;
      sel <= se;
      ies <= 1'b0;
      for (int v = 0; v < 2; v++)
      begin
         ec(1'b1, v[0]);
         ec(1'b0, ~v[0]);
         chk("core_in pair", ci, se ? {1'b0, v[0]} : {~v[0], v[0]});
      end
      $display("input double rate done");
   endtask
   task t_in_rsy;
      @(posedge clk_sys);
      irs <= 1'b1;
      sel <= 1'b0;
      ec(1'b1, 1'b1);
      ec(1'b0, 1'b0);
      ec(1'b1, 1'b1);
      chk("resync first", ci, 2'h1);
      ec(1'b0, 1'b1);
      chk("resync held", ci, 2'h1);
      ec(1'b1, 1'b0);
      chk("resync second", ci, 2'h3);
      $display("input resync done");
   endtask
   task t_out_sdr;
      @(posedge clk_sys);
      ore <= 1'b1;
      oer <= 1'b1;
      el(1'b0, 2'h0, 1'b0);
      for (int e = 0; e < 2; e++)
      begin
         @(posedge clk_sys);
         oes <= e[0];
         oee <= e[0];
         el(1'b1, 2'h0, 1'b0);
         el(1'b0, 2'h0, 1'b0);
         el(1'b1, 2'h1, 1'b1);
         chk("pad_out rise", po, e[0]);
         chk("pad_oe rise", poe, {1'b0, ~e[0]});
         el(1'b0, 2'h1, 1'b1);
         chk("pad_out fall", po, 1'b0);
         chk("pad_oe fall", poe, 1'b1);
      end
      $display("output register done");
   endtask
   task t_out_ddr;
      @(posedge clk_sys);
      odr <= 1'b1;
      oer <= 1'b0;
      inv <= 1'b0;
      for (int r = 0; r < 2; r++)
      begin
         @(posedge clk_sys);
         ors <= r[0];
         el(1'b1, 2'h1, 1'b1);
         chk("pad_out high", po, 1'b1);
         el(1'b0, 2'h2, 1'b1);
         chk("pad_out low", po, {1'b0, ~r[0]});
      end
      // Single-ended pad: falls back to the falling-edge output register
      @(posedge clk_sys);
      sel <= 1'b1;
      el(1'b1, 2'h0, 1'b1);
      el(1'b0, 2'h1, 1'b1);
      chk("pad_out single", po, 2'h1);
      $display("output double rate done");
   endtask
   // Main sequence
   initial
   begin
      {cap, lch, ire, ies, ore, oes, oer, oee} = 8'h00;
      {inv, idr, odr, irs, ors, sel, coe, ext} = 8'h80;
      co = 2'h0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_direct();
      t_in_sdr();
      t_in_ddr(1'b0);
      t_in_ddr(1'b1);
      t_in_rsy();
      t_out_sdr();
      t_out_ddr();
      print_verdict();
   end
   // Watchdog against a hang
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      n_fail++;
      print_verdict();
   end
endmodule
`default_nettype wire
